// >>> hw/tics_pkg.sv
package tics_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_ONE = 8'h00;
  localparam logic [7:0] OFS_TWO = 8'h04;
  localparam logic [7:0] OFS_SOFT = 8'h08;
  localparam logic [7:0] OFS_HARD = 8'h0c;
  localparam logic [7:0] OFS_PVEC = 8'h10;

  // trap_status_control_one fields
  localparam int unsigned B_NEST = 15;
  localparam int unsigned B_ADDR = 3;
  localparam int unsigned B_STK = 2;
  localparam int unsigned B_OSC = 1;
  // global_enable_and_edge_control fields
  localparam int unsigned B_GEN = 15;
  localparam int unsigned B_TDIS = 14;
  localparam int unsigned B_SWT = 13;
  localparam int unsigned B_AIVT = 8;
  localparam int unsigned N_EXT = 4;
  // soft_trap_status fields
  localparam int unsigned B_BUS = 9;
  localparam int unsigned B_NVM = 8;
  localparam int unsigned B_LOOP = 4;
  localparam int unsigned B_PLL = 0;
  // hard_trap_status fields
  localparam int unsigned B_ECC = 1;
  localparam int unsigned B_SWHT = 0;
  // pending_vector_and_level fields
  localparam int unsigned B_VCAP = 13;

  // implemented bits; everything else ignores writes and reads zero, except B_TDIS, which reads tdis_q, timed_disable_i registered one cycle
  localparam logic [15:0] MASK_ONE = 16'h800e;
  localparam logic [15:0] MASK_TWO = 16'ha10f;
  localparam logic [15:0] MASK_SOFT = 16'h0311;
  localparam logic [15:0] MASK_HARD = 16'h0003;

  // values after reset
  localparam logic [15:0] RST_ONE = 16'h0000;
  localparam logic [15:0] RST_TWO = 16'h8000;
  localparam logic [15:0] RST_SOFT = 16'h0000;
  localparam logic [15:0] RST_HARD = 16'h0000;

  // vector numbers
  localparam int unsigned VEC_OSC = 0;
  localparam int unsigned VEC_ADDR = 1;
  localparam int unsigned VEC_HARD = 2;
  localparam int unsigned VEC_STK = 3;
  localparam int unsigned VEC_MATH = 4;
  localparam int unsigned VEC_SOFT = 6;
  localparam logic [7:0] TRAP_MASK = 8'h5f;
  localparam logic [7:0] VEC_USR_BASE = 8'h08;
  localparam logic [7:0] VEC_RSVD_TOP = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> hw/tics_top.sv
`timescale 1ns/1ps
module tics_top import tics_pkg::*; #(
  parameter int unsigned N_SRC = 8,
  parameter bit HAS_BUS_CTRL = 1'b1
) (
  input wire logic core_clk_i, // system clock
  input wire logic reset_n_i, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [7:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic addr_err_i, // address error trap event
  input wire logic stack_err_i, // stack error trap event
  input wire logic osc_fail_i, // oscillator failure trap event
  input wire logic math_err_i, // math error trap pending
  input wire logic bus_addr_err_i, // bus-controller address soft trap
  input wire logic nvm_addr_err_i, // memory address soft trap
  input wire logic loop_ovf_i, // loop stack overflow soft trap
  input wire logic aux_pll_unlock_i, // aux pll lost lock
  input wire logic dbl_bit_err_i, // ecc double-bit error
  input wire logic sw_hard_trap_i, // software hard trap
  input wire logic timed_disable_i, // timed disable running
  input wire logic [N_EXT-1:0] ext_irq_i, // external interrupt levels
  input wire logic [N_SRC-1:0] irq_pend_i, // enabled user sources pending
  input wire logic [3*N_SRC-1:0] irq_level_i, // 3-bit level per source
  input wire logic interrupt_acknowledge_i, // cpu acknowledge pulse
  output logic irq_req_o, // request to cpu
  output logic [7:0] irq_vector_o, // winning vector
  output logic [3:0] irq_level_o, // winning level
  output logic [N_EXT-1:0] ext_irq_event_o, // detected edges
  output logic alt_vector_table_o, // alternate table select
  output logic nesting_disable_o, // nesting disabled
  output logic software_trap_control_o // software trap enabled
);

  tics_vec_if #(.N_SRC(N_SRC)) vif ();

  tics_vec_enc #(.N_SRC(N_SRC)) u_enc (
    .vif(vif.enc)
  );

  logic awready_q, wready_q, aw_got_q, w_got_q, bvalid_q, arready_q;
  logic rvalid_q, vcap_q, tdis_q, irq_req_q;
  logic [7:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q, bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] one_q, two_q, soft_q, hard_q;
  logic [7:0] vec_q, irq_vec_q;
  logic [3:0] lvl_q, irq_lvl_q;
  logic [N_EXT-1:0] ext_prev_q, ext_evt_q;
  logic wr_en, rd_hit, wr_hit;
  logic [15:0] wmask, soft_mask, one_ev, soft_ev, hard_ev, rd_word;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  assign soft_mask = HAS_BUS_CTRL ? MASK_SOFT
                                  : (MASK_SOFT & ~(16'h0001 << B_BUS));
  assign wr_en = aw_got_q & w_got_q & ~bvalid_q;
  assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_hit = (awaddr_q == OFS_ONE) || (awaddr_q == OFS_TWO) ||
                  (awaddr_q == OFS_SOFT) || (awaddr_q == OFS_HARD) ||
                  (awaddr_q == OFS_PVEC);

  // write address channel
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      awready_q <= 1'b1;
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid_i && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr_i[7:2], 2'b00};
    end else if (bvalid_q && s_axi_bready_i) begin
      awready_q <= 1'b1;
      aw_got_q <= 1'b0;
    end
  end

  // write data channel
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wready_q <= 1'b1;
      w_got_q <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end else if (s_axi_wvalid_i && wready_q) begin
      wready_q <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata_i[15:0];
      wstrb_q <= s_axi_wstrb_i[1:0];
    end else if (bvalid_q && s_axi_bready_i) begin
      wready_q <= 1'b1;
      w_got_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // hardware events, placed at their flag positions
  always_comb begin
    one_ev = 16'h0000;
    soft_ev = 16'h0000;
    hard_ev = 16'h0000;
    one_ev[B_ADDR] = addr_err_i;
    one_ev[B_STK] = stack_err_i;
    one_ev[B_OSC] = osc_fail_i;
    soft_ev[B_BUS] = bus_addr_err_i & HAS_BUS_CTRL;
    soft_ev[B_NVM] = nvm_addr_err_i;
    soft_ev[B_LOOP] = loop_ovf_i;
    soft_ev[B_PLL] = aux_pll_unlock_i;
    hard_ev[B_ECC] = dbl_bit_err_i;
    hard_ev[B_SWHT] = sw_hard_trap_i;
  end

  // sticky flags: event set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      one_q <= RST_ONE;
    end else if (wr_en && awaddr_q == OFS_ONE) begin
      one_q <= merge(one_q, wdata_q, wmask & MASK_ONE) | one_ev;
    end else begin
      one_q <= one_q | one_ev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      soft_q <= RST_SOFT;
    end else if (wr_en && awaddr_q == OFS_SOFT) begin
      soft_q <= merge(soft_q, wdata_q, wmask & soft_mask) | soft_ev;
    end else begin
      soft_q <= soft_q | soft_ev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      hard_q <= RST_HARD;
    end else if (wr_en && awaddr_q == OFS_HARD) begin
      hard_q <= merge(hard_q, wdata_q, wmask & MASK_HARD) | hard_ev;
    end else begin
      hard_q <= hard_q | hard_ev;
    end
  end

  // enable, software trap, table select and edge polarity
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      two_q <= RST_TWO;
    end else if (wr_en && awaddr_q == OFS_TWO) begin
      two_q <= merge(two_q, wdata_q, wmask & MASK_TWO);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      vcap_q <= 1'b0;
    end else if (wr_en && awaddr_q == OFS_PVEC && wmask[B_VCAP]) begin
      vcap_q <= wdata_q[B_VCAP];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tdis_q <= 1'b0;
    end else begin
      tdis_q <= timed_disable_i;
    end
  end

  // external edge detect, polarity per bit
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ext_prev_q <= '0;
      ext_evt_q <= '0;
    end else begin
      ext_prev_q <= ext_irq_i;
      ext_evt_q <= (two_q[N_EXT-1:0] & ext_prev_q & ~ext_irq_i) |
                   (~two_q[N_EXT-1:0] & ~ext_prev_q & ext_irq_i);
    end
  end

  // encoder inputs: pending traps from flags and math_err_i, users gated by enable
  always_comb begin
    vif.trap_pend = 8'h00;
    vif.trap_pend[VEC_OSC] = one_q[B_OSC];
    vif.trap_pend[VEC_ADDR] = one_q[B_ADDR];
    vif.trap_pend[VEC_HARD] = |hard_q;
    vif.trap_pend[VEC_STK] = one_q[B_STK];
    vif.trap_pend[VEC_MATH] = math_err_i;
    vif.trap_pend[VEC_SOFT] = |soft_q;
    vif.usr_pend = irq_pend_i & {N_SRC{two_q[B_GEN]}};
    vif.usr_lvl = irq_level_i;
  end

  // vector capture: live or latched at acknowledge
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      vec_q <= 8'h00;
      lvl_q <= 4'h0;
    end else if (vcap_q || interrupt_acknowledge_i) begin
      vec_q <= vif.vec;
      lvl_q <= vif.lvl;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 8'h00;
      irq_lvl_q <= 4'h0;
    end else begin
      irq_req_q <= vif.hit;
      irq_vec_q <= vif.vec;
      irq_lvl_q <= vif.lvl;
    end
  end

  // read mux
  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr_i[7:2], 2'b00})
      OFS_ONE: rd_word = one_q & MASK_ONE;
      OFS_TWO: begin
        rd_word = two_q & MASK_TWO;
        rd_word[B_TDIS] = tdis_q;
      end
      OFS_SOFT: rd_word = soft_q & soft_mask;
      OFS_HARD: rd_word = hard_q & MASK_HARD;
      OFS_PVEC: rd_word = {2'b00, vcap_q, 1'b0, lvl_q, vec_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid_i && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= {16'h0000, rd_word};
    end else if (rvalid_q && s_axi_rready_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;
  assign irq_req_o = irq_req_q;
  assign irq_vector_o = irq_vec_q;
  assign irq_level_o = irq_lvl_q;
  assign ext_irq_event_o = ext_evt_q;
  assign alt_vector_table_o = two_q[B_AIVT];
  assign nesting_disable_o = one_q[B_NEST];
  assign software_trap_control_o = two_q[B_SWT];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_ADDR_SET: assert property (addr_err_i |=> one_q[B_ADDR])
    else $error("address error flag not set");
  AST_STK_SET: assert property (stack_err_i |=> one_q[B_STK])
    else $error("stack error flag not set");
  AST_OSC_STICKY: assert property (
    one_q[B_OSC] && !(wr_en && awaddr_q == OFS_ONE) |=> one_q[B_OSC])
    else $error("oscillator flag dropped without a write");
  AST_GEN_BLOCK: assert property (
    !two_q[B_GEN] && vif.trap_pend == 8'h00 |=> !irq_req_q)
    else $error("user interrupt passed with enable clear");
  AST_EDGE_RISE: assert property (
    !two_q[0] && !ext_irq_i[0] ##1 ext_irq_i[0] && !two_q[0]
    |=> ext_evt_q[0])
    else $error("rising edge on external irq 0 missed");
  AST_UNIMPL_ZERO: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000
    && !s_axi_rdata_o[12])
    else $error("unimplemented read bits not zero");
  AST_DBE_SET: assert property (dbl_bit_err_i |=> hard_q[B_ECC])
    else $error("double-bit error flag not set");
  AST_VEC_LIVE: assert property (
    vcap_q |=> vec_q == $past(vif.vec) && lvl_q == $past(vif.lvl))
    else $error("live vector not tracking encoder");
  AST_VEC_HOLD: assert property (
    !vcap_q && !interrupt_acknowledge_i |=> $stable(vec_q))
    else $error("latched vector changed without acknowledge");
  AST_VEC_RSVD: assert property (
    vif.hit |-> vif.vec != 8'h05 && vif.vec != 8'h07
    && vif.vec != VEC_RSVD_TOP)
    else $error("reserved vector produced");
  AST_SET_WINS: assert property (
    wr_en && awaddr_q == OFS_HARD && sw_hard_trap_i |=> hard_q[B_SWHT])
    else $error("clear beat a simultaneous hard trap");
  AST_BRESP_TIME: assert property (wr_en |=> s_axi_bvalid_o)
    else $error("write response late");

endmodule

// >>> hw/tics_vec_enc.sv
`timescale 1ns/1ps
module tics_vec_enc import tics_pkg::*; #(
  parameter int unsigned N_SRC = 8
) (
  tics_vec_if.enc vif // pending sources in, winner out
);

  logic trap_hit;
  logic usr_hit;
  logic [7:0] tvec;
  logic [7:0] uidx;
  logic [2:0] best;
  logic [2:0] cur;

  // traps beat users; lowest trap vector wins; reserved codes masked
  always_comb begin
    trap_hit = 1'b0;
    usr_hit = 1'b0;
    tvec = 8'h00;
    uidx = 8'h00;
    best = 3'h0;
    cur = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (vif.trap_pend[i] && TRAP_MASK[i]) begin
        trap_hit = 1'b1;
        tvec = 8'(i);
      end
    end
    // level 0 never requests; ties go to the lower vector
    for (int i = N_SRC - 1; i >= 0; i--) begin
      cur = vif.usr_lvl[3*i +: 3];
      if (vif.usr_pend[i] && cur != 3'h0 && cur >= best) begin
        best = cur;
        uidx = 8'(i);
        usr_hit = 1'b1;
      end
    end
  end

  always_comb begin
    vif.hit = trap_hit | usr_hit;
    vif.vec = 8'h00;
    vif.lvl = 4'h0;
    if (trap_hit) begin
      vif.vec = tvec;
      vif.lvl = 4'hf - tvec[3:0];
    end else if (usr_hit) begin
      vif.vec = VEC_USR_BASE + uidx;
      vif.lvl = {1'b0, best};
    end
  end

endmodule

// >>> hw/tics_vec_if.sv
`timescale 1ns/1ps
interface tics_vec_if #(
  parameter int unsigned N_SRC = 8
);
  logic [7:0] trap_pend;
  logic [N_SRC-1:0] usr_pend;
  logic [3*N_SRC-1:0] usr_lvl;
  logic hit;
  logic [7:0] vec;
  logic [3:0] lvl;

  modport enc (
    input trap_pend,
    input usr_pend,
    input usr_lvl,
    output hit,
    output vec,
    output lvl
  );

  modport ctl (
    output trap_pend,
    output usr_pend,
    output usr_lvl,
    input hit,
    input vec,
    input lvl
  );
endinterface

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench import tics_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic math_err = 1'b0, timed_dis = 1'b0, ack_pulse;
  logic [3:0] ext_irq = 4'h0;
  logic [3:0] ext_ev;
  logic [7:0] irq_pend = 8'h00;
  logic [23:0] irq_lvl = 24'h0;
  logic [8:0] trap;
  logic irq_req, alt_tbl, nest_dis, sw_trap;
  logic [7:0] irq_vec;
  logic [3:0] irq_lv;
  int n_errors = 0;
  int compares = 0;
  int ev_cnt [4] = '{0, 0, 0, 0};

  always #2 clk = ~clk;

  // count detected edge pulses per line
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (ext_ev[k] === 1'b1) ev_cnt[k]++;
    end
  end

  tics_far_model far (.clk_i(clk), .trap_o(trap), .ack_o(ack_pulse));

  tics_top #(.N_SRC(8), .HAS_BUS_CTRL(1'b1)) DUT (
    .core_clk_i(clk), .reset_n_i(reset_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .addr_err_i(trap[0]), .stack_err_i(trap[1]), .osc_fail_i(trap[2]),
    .math_err_i(math_err), .bus_addr_err_i(trap[3]),
    .nvm_addr_err_i(trap[4]), .loop_ovf_i(trap[5]),
    .aux_pll_unlock_i(trap[6]), .dbl_bit_err_i(trap[7]),
    .sw_hard_trap_i(trap[8]), .timed_disable_i(timed_dis),
    .ext_irq_i(ext_irq), .irq_pend_i(irq_pend), .irq_level_i(irq_lvl),
    .interrupt_acknowledge_i(ack_pulse), .irq_req_o(irq_req),
    .irq_vector_o(irq_vec), .irq_level_o(irq_lv),
    .ext_irq_event_o(ext_ev), .alt_vector_table_o(alt_tbl),
    .nesting_disable_o(nest_dis), .software_trap_control_o(sw_trap)
  );

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic t_reset();
    rd(OFS_ONE, 32'h0000, RESP_OKAY);
    rd(OFS_TWO, 32'h8000, RESP_OKAY);
    rd(OFS_SOFT, 32'h0000, RESP_OKAY);
    rd(OFS_HARD, 32'h0000, RESP_OKAY);
    rd(OFS_PVEC, 32'h0000, RESP_OKAY);
    rd(8'h14, 32'h0000, RESP_SLVERR);
    wr(8'h14, 16'hffff, RESP_SLVERR);
  endtask

  task automatic t_flags();
    for (int i = 0; i < 9; i++) far.fire(i);
    rd(OFS_ONE, 32'h000e, RESP_OKAY);
    rd(OFS_SOFT, 32'h0311, RESP_OKAY);
    rd(OFS_HARD, 32'h0003, RESP_OKAY);
    wr(OFS_ONE, 16'h0000, RESP_OKAY);
    wr(OFS_SOFT, 16'h0000, RESP_OKAY);
    wr(OFS_HARD, 16'h0000, RESP_OKAY);
    rd(OFS_ONE, 32'h0000, RESP_OKAY);
    rd(OFS_SOFT, 32'h0000, RESP_OKAY);
    rd(OFS_HARD, 32'h0000, RESP_OKAY);
    // hard trap lands in the very cycle of the clearing write
    fork
      wr(OFS_HARD, 16'h0000, RESP_OKAY);
      begin
        @(posedge clk);
        far.fire(8);
      end
    join
    rd(OFS_HARD, 32'h0001, RESP_OKAY);
    wr(OFS_HARD, 16'h0000, RESP_OKAY);
    rd(OFS_HARD, 32'h0000, RESP_OKAY);
  endtask

  task automatic t_ctrl();
    wr(OFS_TWO, 16'hffff, RESP_OKAY);
    rd(OFS_TWO, 32'ha10f, RESP_OKAY);
    chk({31'h0, alt_tbl}, 32'h1);
    chk({31'h0, sw_trap}, 32'h1);
    @(posedge clk);
    timed_dis <= 1'b1;
    rd(OFS_TWO, 32'he10f, RESP_OKAY);
    @(posedge clk);
    timed_dis <= 1'b0;
    wr(OFS_ONE, 16'h8001, RESP_OKAY);
    rd(OFS_ONE, 32'h8000, RESP_OKAY);
    chk({31'h0, nest_dis}, 32'h1);
    wr(OFS_ONE, 16'h0000, RESP_OKAY);
    chk({31'h0, nest_dis}, 32'h0);
    wr(OFS_TWO, 16'h8000, RESP_OKAY);
    chk({31'h0, alt_tbl}, 32'h0);
    chk({31'h0, sw_trap}, 32'h0);
  endtask

  // drive all lines to lvl and count pulses that follow
  task automatic edges(input logic [3:0] lvl, input int expn);
    int b [4];
    b = ev_cnt;
    @(posedge clk);
    ext_irq <= lvl;
    repeat (6) @(posedge clk);
    for (int k = 0; k < 4; k++) chk(ev_cnt[k] - b[k], expn);
  endtask

  task automatic t_edge();
    edges(4'hf, 1);
    edges(4'h0, 0);
    wr(OFS_TWO, 16'h800f, RESP_OKAY);
    edges(4'hf, 0);
    edges(4'h0, 1);
    wr(OFS_TWO, 16'h8000, RESP_OKAY);
  endtask

  task automatic t_vec();
    int tidx [5] = '{0, 1, 2, 8, 6};
    logic [7:0] tofs [5] = '{OFS_ONE, OFS_ONE, OFS_ONE, OFS_HARD, OFS_SOFT};
    logic [31:0] texp [5] = '{32'h2e01, 32'h2c03, 32'h2f00, 32'h2d02,
                              32'h2906};
    @(posedge clk);
    irq_lvl <= 24'h000028;
    irq_pend <= 8'h02;
    wr(OFS_PVEC, 16'h2000, RESP_OKAY);
    rd(OFS_PVEC, 32'h2509, RESP_OKAY);
    chk({24'h0, irq_vec}, 32'h09);
    chk({28'h0, irq_lv}, 32'h5);
    @(posedge clk);
    math_err <= 1'b1;
    rd(OFS_PVEC, 32'h2b04, RESP_OKAY);
    @(posedge clk);
    math_err <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      far.fire(tidx[i]);
      rd(OFS_PVEC, texp[i], RESP_OKAY);
      wr(tofs[i], 16'h0000, RESP_OKAY);
    end
    // users blocked, traps still pass
    wr(OFS_TWO, 16'h0000, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_req}, 32'h0);
    far.fire(0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_req}, 32'h1);
    wr(OFS_ONE, 16'h0000, RESP_OKAY);
    wr(OFS_TWO, 16'h8000, RESP_OKAY);
    // capture only at acknowledge
    wr(OFS_PVEC, 16'h0000, RESP_OKAY);
    far.ack();
    rd(OFS_PVEC, 32'h0509, RESP_OKAY);
    @(posedge clk);
    irq_pend <= 8'h03;
    irq_lvl <= 24'h00002f;
    rd(OFS_PVEC, 32'h0509, RESP_OKAY);
    far.ack();
    rd(OFS_PVEC, 32'h0708, RESP_OKAY);
    chk({24'h0, irq_vec}, 32'h08);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    $display("ERROR %0t: watchdog expired", $time);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_flags();
    t_ctrl();
    t_edge();
    t_vec();
    tally_and_finish();
  end
endmodule

// >>> testbench/tics_far_model.sv
`timescale 1ns/1ps
module tics_far_model (
  input wire logic clk_i, // system clock
  output logic [8:0] trap_o, // trap event pulses
  output logic ack_o // cpu acknowledge pulse
);
  initial begin
    trap_o = 9'h000;
    ack_o = 1'b0;
  end

  // one-cycle event from a trap source
  task automatic fire(input int i);
    @(posedge clk_i);
    trap_o[i] <= 1'b1;
    @(posedge clk_i);
    trap_o[i] <= 1'b0;
  endtask

  // cpu takes the pending interrupt, one cycle
  task automatic ack();
    @(posedge clk_i);
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
  endtask
endmodule
